/* File: core/pvo_defines.vh */
/*
 * constants for the parallel video output port: apb register offsets,
 * field positions, reset values, ratio codes, pixel bit positions and timing counts.
 * assumes it is included by bare name from the core design files.
 */
`ifndef PVO_DEFINES_VH
`define PVO_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define PVO_OFS_CTRL        8'h00
`define PVO_OFS_GPO         8'h04
`define PVO_OFS_GPIO        8'h08
`define PVO_OFS_STATUS      8'h0C

////////////////////////////////////////////////////////////////////////////////
// control register fields
`define PVO_CTRL_EDGE       0
`define PVO_CTRL_DEFILT     1
`define PVO_CTRL_COLOR18    2
`define PVO_CTRL_RATIO_LO   3
`define PVO_CTRL_RATIO_HI   4
`define PVO_CTRL_RST        5'h03

// audio master clock ratio codes
`define PVO_RATIO_X1        2'h0
`define PVO_RATIO_X2        2'h1
`define PVO_RATIO_X4        2'h2

////////////////////////////////////////////////////////////////////////////////
// general output register: enables in 4:0, levels in 12:8, index 4..8
`define PVO_GPO_EN_LO       0
`define PVO_GPO_EN_HI       4
`define PVO_GPO_LVL_LO      8
`define PVO_GPO_LVL_HI      12
`define PVO_GPO_RST         5'h00

// general io register: levels in 3:0, enables in 7:4
`define PVO_GPIO_OUT_LO     0
`define PVO_GPIO_OUT_HI     3
`define PVO_GPIO_OE_LO      4
`define PVO_GPIO_OE_HI      7
`define PVO_GPIO_RST        4'h0

// status register fields
`define PVO_ST_LOCK         0
`define PVO_ST_COLOR18      1
`define PVO_ST_INTR         2
`define PVO_ST_STCLK        3
`define PVO_ST_PDB          4
`define PVO_ST_GPIO_LO      8
`define PVO_ST_GPIO_HI      11

////////////////////////////////////////////////////////////////////////////////
// pixel bit positions taken over by gpio and audio data b in 18-bit mode, and by outputs 4, 5
`define PVO_BIT_GPIO0       0
`define PVO_BIT_GPIO1       1
`define PVO_BIT_GPIO2       8
`define PVO_BIT_GPIO3       9
`define PVO_BIT_GPO4        16
`define PVO_BIT_GPO5        17

////////////////////////////////////////////////////////////////////////////////
// timing counts, in pixel clocks
`define PVO_DE_MIN_PCLK     2'h3

`endif

/* File: core/pvo_sync2.v */
/*
 * two flip-flop synchroniser for a group of asynchronous levels.
 * assumes each bit is a level that holds several mclk cycles.
 */
`timescale 1ns/1ps

module pvo_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             mclk,
  input  wire             rst_n,
  // asynchronous input and synchronised output
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_q;  // first stage, read only by the second stage
  reg [WIDTH-1:0] sync_q;  // second stage

  // two flop chain
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // pvo_sync2

/* File: core/pvo_port.v */
/*
 * parallel video output port: forwards recovered pixel data, sync, data
 * enable, pixel clock and audio to the pins, with de filter, pin sharing,
 * general outputs and output state control. apb register slave.
 * assumes all link-side inputs are asynchronous to mclk and that the
 * recovered pixel clock is much slower than mclk (eight or more cycles).
 */
// Notes on behaviour
// [R1] source keeps vsync transitions 130 pclks apart
// [R2] filter on: de pulses under three pclks dropped
// [R3] filter off: de forwarded as received
// [R4] source keeps de to two transitions/130 pclks
// [R5] data launched on register-chosen pixel clock edge
// [R6] audio clock, word clock, data a become outputs 8,7,6
// [R7] audio master clock is x1, x2 or x4 bit clock
// [R8] 18-bit mode: blue bit 1 carries audio data b
// [R9] 18-bit mode: four gpio replace low red, green
// [R10] five register outputs, index four to eight
// [R11] shared pin: interrupt or selftest clock select
// [R12] power-down low: outputs hi-z, clock recovery stops
// [R13] unlocked: output enable pin governs outputs; locked drives
// [R14] enable and sleep select choose drive, sleep, hi-z
`timescale 1ns/1ps
`include "pvo_defines.vh"

module pvo_port (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // recovered link side
  input  wire        pix_clk_in,
  input  wire [23:0] pix_data_in,
  input  wire        vsync_in,
  input  wire        de_in,
  input  wire        lock_in,
  input  wire        aud_bclk_in,
  input  wire        aud_wclk_in,
  input  wire        aud_da_in,
  input  wire        aud_db_in,
  // control pins
  input  wire        power_down_bar,
  input  wire        output_enable_pin,
  input  wire        output_sleep_state_select,
  input  wire        mode_sel_18bit,
  input  wire        selftest_enable,
  input  wire        selftest_clock_select,
  // video pins
  output reg  [23:0] pixel_data_out,
  output reg  [23:0] pixel_data_oe,
  input  wire [3:0]  gpio_in,
  output reg         vertical_sync_out,
  output reg         data_enable_out,
  output reg         pixel_clock_out,
  output reg         video_oe,
  // audio pins
  output reg         audio_bit_clock_out,
  output reg         audio_word_clock_out,
  output reg         audio_data_a_out,
  output reg         audio_master_clock_out,
  output reg         audio_oe,
  // clock recovery enable
  output reg         clock_recovery_en
);

  ////////////////////////////////////////////////////////////////////////////
  // output state codes, one-hot
  localparam [2:0] ST_HIZ   = 3'h1;
  localparam [2:0] ST_SLEEP = 3'h2;
  localparam [2:0] ST_DRIVE = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised inputs
  wire [26:0] vid_s;   // pixel clock, vsync, de, data
  wire [3:0]  aud_s;   // bit clock, word clock, data a, data b
  wire [6:0]  ctl_s;   // lock, pdb, oen, oss, mode, selftest, shared pin
  wire [3:0]  gpio_s;  // gpio pin levels

  // one chain for every pin and link level
  pvo_sync2 #(.WIDTH(42)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({pix_clk_in, vsync_in, de_in, pix_data_in, aud_bclk_in, aud_wclk_in, aud_da_in,
             aud_db_in, lock_in, power_down_bar, output_enable_pin, output_sleep_state_select,
             mode_sel_18bit, selftest_enable, selftest_clock_select, gpio_in}),
    .q     ({vid_s, aud_s, ctl_s, gpio_s})
  );

  wire        pclk_s   = vid_s[26];
  wire        vs_s     = vid_s[25];
  wire        de_s     = vid_s[24];
  wire [23:0] data_s   = vid_s[23:0];
  wire        bclk_s   = aud_s[3];
  wire        lock_s   = ctl_s[6];
  wire        pdb_s    = ctl_s[5];
  wire        oen_s    = ctl_s[4];
  wire        oss_s    = ctl_s[3];
  wire        mode_s   = ctl_s[2];
  wire        sten_s   = ctl_s[1];
  wire        shared_s = ctl_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [4:0] ctrl_q;       // edge, filter, 18-bit force, ratio
  reg  [4:0] gpo_en_q;     // enables for outputs 4..8
  reg  [4:0] gpo_lvl_q;    // levels for outputs 4..8
  reg  [3:0] gpio_out_q;   // gpio drive levels
  reg  [3:0] gpio_oe_q;    // gpio drive enables
  reg  [2:0] out_state_q;  // output state
  reg  [31:0] rd_d;        // read mux
  reg        hit_d;        // address decodes

  wire color18 = mode_s | ctrl_q[`PVO_CTRL_COLOR18];  // pin or register   [R8] [R9]
  wire intr_in = ~sten_s & shared_s;                   // interrupt meaning  [R11]
  wire st_clk  = sten_s & shared_s;                    // selftest meaning   [R11]

  // read mux and decode
  always @* begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      `PVO_OFS_CTRL: rd_d[4:0] = ctrl_q;
      `PVO_OFS_GPO: begin
        rd_d[`PVO_GPO_EN_HI:`PVO_GPO_EN_LO]   = gpo_en_q;
        rd_d[`PVO_GPO_LVL_HI:`PVO_GPO_LVL_LO] = gpo_lvl_q;
      end
      `PVO_OFS_GPIO: begin
        rd_d[`PVO_GPIO_OUT_HI:`PVO_GPIO_OUT_LO] = gpio_out_q;
        rd_d[`PVO_GPIO_OE_HI:`PVO_GPIO_OE_LO]   = gpio_oe_q;
      end
      `PVO_OFS_STATUS: begin
        rd_d[`PVO_ST_LOCK]    = lock_s;
        rd_d[`PVO_ST_COLOR18] = color18;
        rd_d[`PVO_ST_INTR]    = intr_in;  // [R11]
        rd_d[`PVO_ST_STCLK]   = st_clk;
        rd_d[`PVO_ST_PDB]     = pdb_s;
        rd_d[`PVO_ST_GPIO_HI:`PVO_ST_GPIO_LO] = gpio_s;
      end
      default: hit_d = 1'b0;
    endcase
  end

  // apb slave: answer registered in setup, write in access
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      ctrl_q     <= `PVO_CTRL_RST;
      gpo_en_q   <= `PVO_GPO_RST;
      gpo_lvl_q  <= `PVO_GPO_RST;
      gpio_out_q <= `PVO_GPIO_RST;
      gpio_oe_q  <= `PVO_GPIO_RST;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_d;
      // setup phase: latch the read data for the access phase
      if (psel & ~penable)
        prdata <= pwrite ? 32'h0000_0000 : rd_d;
      // access phase: write takes effect
      if (psel & penable & pready & pwrite)
        case (paddr)
          `PVO_OFS_CTRL: ctrl_q <= pwdata[4:0];
          `PVO_OFS_GPO: begin
            gpo_en_q  <= pwdata[`PVO_GPO_EN_HI:`PVO_GPO_EN_LO];
            gpo_lvl_q <= pwdata[`PVO_GPO_LVL_HI:`PVO_GPO_LVL_LO];
          end
          `PVO_OFS_GPIO: begin
            gpio_out_q <= pwdata[`PVO_GPIO_OUT_HI:`PVO_GPIO_OUT_LO];
            gpio_oe_q  <= pwdata[`PVO_GPIO_OE_HI:`PVO_GPIO_OE_LO];
          end
          default: ;  // read-only or unmapped: no effect
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output state: power-down, lock, enable pin, sleep select
  wire [2:0] out_state_d = !pdb_s           ? ST_HIZ   :  // [R12]
                           (lock_s | oen_s) ? ST_DRIVE :  // [R13]
                           oss_s            ? ST_SLEEP :  // [R14]
                                              ST_HIZ;     // [R14]

  ////////////////////////////////////////////////////////////////////////////
  // pixel clock edge detect and de filter
  reg        pclk_d1_q;    // delayed synced pixel clock
  reg        de_filt_q;    // filtered de level
  reg  [1:0] de_cnt_q;     // pclks the new de level has been held
  wire       rise = pclk_s & ~pclk_d1_q;
  wire       fall = ~pclk_s & pclk_d1_q;
  wire       launch = ctrl_q[`PVO_CTRL_EDGE] ? rise : fall;  // [R5]

  // de filter runs on the launch edge
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pclk_d1_q <= 1'b0;
      de_filt_q <= 1'b0;
      de_cnt_q  <= 2'h0;
    end else begin
      pclk_d1_q <= pclk_s;
      if (launch) begin
        if (!ctrl_q[`PVO_CTRL_DEFILT]) begin
          de_filt_q <= de_s;                   // [R3]
          de_cnt_q  <= 2'h0;
        end else if (de_s == de_filt_q) begin
          de_cnt_q  <= 2'h0;                   // [R2]
        end else if (de_cnt_q == `PVO_DE_MIN_PCLK - 2'h1) begin
          de_filt_q <= de_s;                   // [R2]
          de_cnt_q  <= 2'h0;
        end else begin
          de_cnt_q  <= de_cnt_q + 2'h1;        // [R2]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // audio master clock: measure bit clock half period, divide it down
  reg [15:0] half_cnt_q;   // cycles since last bit clock edge
  reg [15:0] half_q;       // last measured half period
  reg [15:0] div_cnt_q;    // master clock divider
  reg        bclk_d1_q;    // delayed synced bit clock
  reg        mck_q;        // divided master clock
  reg [15:0] div_len;      // half period of master clock
  wire       b_edge = bclk_s ^ bclk_d1_q;

  // divider length from ratio
  always @* begin
    case (ctrl_q[`PVO_CTRL_RATIO_HI:`PVO_CTRL_RATIO_LO])
      `PVO_RATIO_X2: div_len = {1'b0, half_q[15:1]};
      `PVO_RATIO_X4: div_len = {2'b00, half_q[15:2]};
      default:       div_len = half_q;
    endcase
    if (div_len == 16'h0000)
      div_len = 16'h0001;
  end

  // half period measure and master clock toggle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_q <= 16'h0000;
      half_q     <= 16'h0001;
      div_cnt_q  <= 16'h0000;
      bclk_d1_q  <= 1'b0;
      mck_q      <= 1'b0;
    end else begin
      bclk_d1_q <= bclk_s;
      if (b_edge) begin
        half_q     <= half_cnt_q + 16'h0001;
        half_cnt_q <= 16'h0000;
      end else if (half_cnt_q != 16'hFFFF) begin
        half_cnt_q <= half_cnt_q + 16'h0001;
      end
      if (b_edge & bclk_s) begin
        // realign phase on each bit clock rise
        mck_q     <= 1'b1;
        div_cnt_q <= 16'h0000;
      end else if (div_cnt_q + 16'h0001 >= div_len) begin
        mck_q     <= ~mck_q;                   // [R7]
        div_cnt_q <= 16'h0000;
      end else begin
        div_cnt_q <= div_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers
  reg [23:0] pix_d;        // pixel bits after pin sharing
  reg [23:0] pix_oe_d;     // per bit enables
  wire       drv   = out_state_q[2];
  wire       en    = out_state_q[2] | out_state_q[1];

  // pin sharing on the pixel bus
  always @* begin
    pix_d    = data_s;
    pix_oe_d = {24{en}};
    if (color18) begin
      {pix_d[`PVO_BIT_GPIO3:`PVO_BIT_GPIO2],
       pix_d[`PVO_BIT_GPIO1:`PVO_BIT_GPIO0]} = gpio_out_q;                   // [R9]
      {pix_oe_d[`PVO_BIT_GPIO3:`PVO_BIT_GPIO2],
       pix_oe_d[`PVO_BIT_GPIO1:`PVO_BIT_GPIO0]} = {4{pdb_s}} & gpio_oe_q;    // [R9] [R12]
      pix_d[`PVO_BIT_GPO5]     = aud_s[0];               // [R8]
    end
    if (gpo_en_q[0])
      pix_d[`PVO_BIT_GPO4] = gpo_lvl_q[0];               // [R10]
    if (gpo_en_q[1])
      pix_d[`PVO_BIT_GPO5] = gpo_lvl_q[1];               // [R8] [R10]
  end

  // launch video on the chosen edge, audio continuously
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_state_q            <= ST_HIZ;
      pixel_data_out         <= 24'h00_0000;
      pixel_data_oe          <= 24'h00_0000;
      vertical_sync_out      <= 1'b0;
      data_enable_out        <= 1'b0;
      pixel_clock_out        <= 1'b0;
      video_oe               <= 1'b0;
      audio_bit_clock_out    <= 1'b0;
      audio_word_clock_out   <= 1'b0;
      audio_data_a_out       <= 1'b0;
      audio_master_clock_out <= 1'b0;
      audio_oe               <= 1'b0;
      clock_recovery_en      <= 1'b0;
    end else begin
      out_state_q       <= out_state_d;
      clock_recovery_en <= pdb_s;                              // [R12]
      video_oe          <= en;                                 // [R12] [R13] [R14]
      audio_oe          <= en;
      pixel_data_oe     <= pix_oe_d;
      pixel_clock_out   <= drv & pclk_s;                       // [R5]
      if (!drv) begin
        // sleep level low, or idle while hi-z
        pixel_data_out    <= 24'h00_0000;
        vertical_sync_out <= 1'b0;
        data_enable_out   <= 1'b0;
      end else if (launch) begin
        pixel_data_out    <= pix_d;                            // [R5]
        vertical_sync_out <= vs_s;                             // [R1]
        data_enable_out   <= de_filt_q;                            // [R2] [R3]
      end
      // audio follows its inputs, or its gpo level where enabled, while driving; low otherwise
      audio_bit_clock_out    <= drv & (gpo_en_q[4] ? gpo_lvl_q[4] : bclk_s);    // [R6] [R10]
      audio_word_clock_out   <= drv & (gpo_en_q[3] ? gpo_lvl_q[3] : aud_s[2]);  // [R6] [R10]
      audio_data_a_out       <= drv & (gpo_en_q[2] ? gpo_lvl_q[2] : aud_s[1]);  // [R6] [R10]
      audio_master_clock_out <= drv & ((ctrl_q[`PVO_CTRL_RATIO_HI:`PVO_CTRL_RATIO_LO] ==
                                        `PVO_RATIO_X1) ? bclk_s : mck_q);       // [R7]
    end
  end

endmodule // pvo_port

/* File: dv/pvo_assertions.sv */
/* pin and bus timing checks for pvo_port.
   assumes it is bound onto pvo_port, all in the mclk domain. */
`timescale 1ns/1ps

module pvo_assertions (
  // clock, reset and bus handshake
  input wire        mclk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  // control and link pins
  input wire        power_down_bar,
  input wire        lock_in,
  input wire        output_enable_pin,
  input wire        output_sleep_state_select,
  input wire        pix_clk_in,
  // watched outputs
  input wire        pixel_clock_out,
  input wire        data_enable_out,
  input wire        vertical_sync_out,
  input wire        video_oe,
  input wire        audio_oe,
  input wire [23:0] pixel_data_oe,
  input wire        clock_recovery_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // output state: five cycles covers sync plus state register
  AST_PDB_HIZ: assert property ((!power_down_bar)[*5] |->
    pixel_data_oe == 24'h0 && !video_oe && !audio_oe) else $error("pins driven in power down");
  AST_CR_STOP: assert property ((!power_down_bar)[*5] |-> !clock_recovery_en)
    else $error("clock recovery runs in power down");
  AST_CR_RUN: assert property (power_down_bar[*5] |-> clock_recovery_en)
    else $error("clock recovery stopped while running");
  AST_LOCK_DRIVE: assert property ((power_down_bar && lock_in)[*5] |->
    video_oe && audio_oe) else $error("locked but not driving");
  AST_OEN_DRIVE: assert property ((power_down_bar && !lock_in && output_enable_pin)[*5] |->
    video_oe) else $error("enable pin high but not driving");
  AST_SLEEP_LOW: assert property ((power_down_bar && !lock_in && !output_enable_pin &&
    output_sleep_state_select)[*5] |-> video_oe && !pixel_clock_out && !data_enable_out &&
    !vertical_sync_out) else $error("sleep level not held low");
  AST_SLEEP_HIZ: assert property ((power_down_bar && !lock_in && !output_enable_pin &&
    !output_sleep_state_select)[*5] |-> !video_oe && !audio_oe) else $error("not released");

  ////////////////////////////////////////////////////////////////////////////////
  // bus answer and pixel timing
  AST_APB_ONE: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single access pulse");
  AST_APB_ERR: assert property (pslverr |-> pready) else $error("error without ready");
  AST_PCLK_FOLLOW: assert property ($rose(pixel_clock_out) && $past(video_oe) |->
    $past(pix_clk_in, 2)) else $error("output clock rose without input clock");
  AST_DE_ON_EDGE: assert property ((power_down_bar && lock_in)[*6] ##0
    $changed(data_enable_out) |-> $changed(pixel_clock_out)) else $error("de moved off edge");

  // main scenarios reached
  cover property (pslverr);
  cover property ($rose(data_enable_out));
  cover property (video_oe && !lock_in && !output_enable_pin && output_sleep_state_select);
endmodule // pvo_assertions

bind pvo_port pvo_assertions u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .power_down_bar(power_down_bar), .lock_in(lock_in),
  .output_enable_pin(output_enable_pin), .output_sleep_state_select(output_sleep_state_select),
  .pix_clk_in(pix_clk_in), .pixel_clock_out(pixel_clock_out), .data_enable_out(data_enable_out),
  .vertical_sync_out(vertical_sync_out), .video_oe(video_oe), .audio_oe(audio_oe),
  .pixel_data_oe(pixel_data_oe), .clock_recovery_en(clock_recovery_en));

/* File: dv/pvo_panel_model.sv */
/* display panel model: captures pixels on the non-launch clock edge and
   resolves the four shared gpio wires (pulled down when undriven). */
`timescale 1ns/1ps

module pvo_panel_model (
  // video from the port
  input  wire        launch_rise,
  input  wire        pixel_clock_out,
  input  wire [23:0] pixel_data_out,
  input  wire [23:0] pixel_data_oe,
  input  wire        data_enable_out,
  input  wire        vertical_sync_out,
  // outside gpio drivers
  input  wire [3:0]  ext_val,
  input  wire [3:0]  ext_en,
  // captured values and wire levels
  output logic [23:0] cap = 24'h000000,
  output logic        vs_cap = 1'b0,
  output logic [15:0] de_cnt = 16'h0000,
  output wire  [3:0]  gpio_in
);
  // capture mid-pixel, on the edge opposite the launch edge
  always @(pixel_clock_out) begin
    if (pixel_clock_out !== launch_rise) begin
      cap    <= pixel_data_out;
      vs_cap <= vertical_sync_out;
      if (data_enable_out === 1'b1) de_cnt <= de_cnt + 16'h0001;
    end
  end

  // wire level: port driver, else outside driver, else pull-down
  assign gpio_in[0] = pixel_data_oe[0] ? pixel_data_out[0] : (ext_en[0] & ext_val[0]);
  assign gpio_in[1] = pixel_data_oe[1] ? pixel_data_out[1] : (ext_en[1] & ext_val[1]);
  assign gpio_in[2] = pixel_data_oe[8] ? pixel_data_out[8] : (ext_en[2] & ext_val[2]);
  assign gpio_in[3] = pixel_data_oe[9] ? pixel_data_out[9] : (ext_en[3] & ext_val[3]);
endmodule // pvo_panel_model

/* File: dv/pvo_port_bench.sv */
/* self-checking bench for pvo_port: apb master, video and audio source.
   assumes pvo_port, pvo_panel_model and pvo_defines.vh are compiled. */
`timescale 1ns/1ps
`include "pvo_defines.vh"

module pvo_port_bench;
  // bus and control inputs
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic pix_clk_in = 0, vsync_in = 0, de_in = 0, lock_in = 0, launch_rise = 1;
  logic [23:0] pix_data_in = 24'h0;
  logic aud_bclk_in = 0, aud_wclk_in = 0, aud_da_in = 0, aud_db_in = 0;
  logic power_down_bar = 0, output_enable_pin = 0, output_sleep_state_select = 0;
  logic mode_sel_18bit = 0, selftest_enable = 0, selftest_clock_select = 0;
  logic [3:0] ext_val = 4'h0, ext_en = 4'h0;
  // design outputs and panel view
  wire [31:0] prdata;
  wire pready, pslverr, vertical_sync_out, data_enable_out, pixel_clock_out, video_oe;
  wire audio_bit_clock_out, audio_word_clock_out, audio_data_a_out, audio_master_clock_out;
  wire audio_oe, clock_recovery_en, vs_cap;
  wire [23:0] pixel_data_out, pixel_data_oe, cap;
  wire [3:0] gpio_in;
  wire [15:0] de_cnt;
  int n_errors = 0, comparisons = 0, cycles = 0, mck = 0;
  logic [15:0] n0;

  pvo_port u_dut (.*);
  pvo_panel_model u_panel (.*);

  always #50 mclk = ~mclk;
  always @(posedge audio_master_clock_out) mck++;
  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer: hold until pready sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task settle;
    repeat (6) @(posedge mclk);
  endtask

  // one 800 ns pixel clock; data moves a quarter period in
  task pix(input logic [23:0] d, input logic de, input logic vs);
    pix_clk_in <= 1;
    repeat (2) @(posedge mclk);
    pix_data_in <= d; de_in <= de; vsync_in <= vs;
    repeat (2) @(posedge mclk);
    pix_clk_in <= 0;
    repeat (4) @(posedge mclk);
  endtask

  // idle run keeps control transitions 130 pixel clocks apart
  task gap(input logic vs);
    repeat (130) pix(24'h0, 0, vs);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    apb(0, `PVO_OFS_CTRL, 0);  check("ctrl reset", rd, 32'h3);
    apb(0, `PVO_OFS_GPO, 0);   check("gpo reset", rd, 32'h0);
    apb(0, `PVO_OFS_GPIO, 0);  check("gpio reset", rd, 32'h0);
    apb(1, `PVO_OFS_STATUS, 32'hFFFFFFFF);
    apb(0, `PVO_OFS_STATUS, 0); check("status ro", rd, 32'h0);
    apb(1, 8'h10, 32'h1);      check("unmapped wr err", err, 1);
    apb(0, 8'h10, 0);          check("unmapped rd", {err, rd[30:0]}, 32'h80000000);
    apb(1, `PVO_OFS_GPO, 32'hFFFF1F1F);
    apb(0, `PVO_OFS_GPO, 0);   check("gpo rw", rd, 32'h1F1F);
    apb(1, `PVO_OFS_GPO, 0);
    $display("t_regs done");
  endtask

  task t_power;
    power_down_bar <= 1; output_sleep_state_select <= 1; settle;
    check("sleep oe", {video_oe, pixel_clock_out}, 2'b10);
    output_sleep_state_select <= 0; settle;
    check("hiz oe", {video_oe, audio_oe}, 0);
    output_enable_pin <= 1; settle;
    check("oen drive", video_oe, 1);
    output_enable_pin <= 0; lock_in <= 1; settle;
    check("lock drive", {video_oe, audio_oe}, 2'b11);
    power_down_bar <= 0; settle;
    check("pd", {video_oe, audio_oe, clock_recovery_en, pixel_data_oe}, 0);
    power_down_bar <= 1; settle;
    check("run", clock_recovery_en, 1);
    $display("t_power done");
  endtask

  task t_video(input logic edge_rise);
    apb(1, `PVO_OFS_CTRL, {30'h0, 1'b1, edge_rise});
    launch_rise <= edge_rise;
    for (int k = 0; k < 5; k++) begin
      pix({8'h5A, 8'(k), 8'hC3}, 0, 0);
      if (k > 0) check("pixel", cap, {8'h5A, 8'(k - 1), 8'hC3});
    end
    $display("t_video done");
  endtask

  task pulse(input int n);
    n0 = de_cnt;
    repeat (n) pix(24'h0, 1, 0);
    gap(0);
  endtask

  task t_de;
    apb(1, `PVO_OFS_CTRL, 32'h3);
    launch_rise <= 1;
    gap(1);  check("vsync high", vs_cap, 1);
    gap(0);  check("vsync low", vs_cap, 0);
    pulse(2); check("de short dropped", de_cnt - n0, 0);
    pulse(3); check("de three kept", de_cnt - n0, 3);
    apb(1, `PVO_OFS_CTRL, 32'h1);
    pulse(1); check("de unfiltered", de_cnt - n0, 1);
    $display("t_de done");
  endtask

  task t_pins;
    apb(1, `PVO_OFS_GPO, 32'h161F);
    repeat (2) pix(24'h0, 0, 0);
    check("gpo", {audio_bit_clock_out, audio_word_clock_out, audio_data_a_out,
      pixel_data_out[17:16]}, 5'b10110);
    apb(1, `PVO_OFS_GPO, 0);
    mode_sel_18bit <= 1; aud_db_in <= 1;
    repeat (2) pix(24'h0, 0, 0);
    check("audio b", pixel_data_out[17], 1);
    apb(1, `PVO_OFS_GPIO, 32'hF5); repeat (2) pix(24'h0, 0, 0);
    check("gpio out", {pixel_data_out[9:8], pixel_data_out[1:0]}, 4'h5);
    check("gpio oe", {pixel_data_oe[9:8], pixel_data_oe[1:0]}, 4'hF);
    apb(1, `PVO_OFS_GPIO, 0);
    ext_en <= 4'hF; ext_val <= 4'hA; selftest_clock_select <= 1; settle;
    apb(0, `PVO_OFS_STATUS, 0); check("status intr", rd[11:0], 12'hA17);
    selftest_enable <= 1; settle;
    apb(0, `PVO_OFS_STATUS, 0); check("status stclk", rd[11:0], 12'hA1B);
    mode_sel_18bit <= 0; ext_en <= 4'h0;
    $display("t_pins done");
  endtask

  task t_audio;
    for (int r = 0; r < 3; r++) begin
      apb(1, `PVO_OFS_CTRL, 32'h3 | (r << 3));
      mck = 0;
      repeat (20) begin
        aud_bclk_in <= 1; repeat (8) @(posedge mclk);
        aud_bclk_in <= 0; repeat (8) @(posedge mclk);
      end
      check("mclk ratio", mck >= (20 << r) - 3 && mck <= (20 << r) + 1, 1);
    end
    aud_wclk_in <= 1; aud_da_in <= 1; settle;
    check("audio", {audio_word_clock_out, audio_data_a_out}, 2'b11);
    $display("t_audio done");
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    t_regs;
    t_power;
    t_video(1);
    t_video(0);
    t_de;
    t_pins;
    t_audio;
    tally_and_finish();
  end
endmodule // pvo_port_bench
